// *** rtl/cca_pkg.sv ***
// Shared constants and carriers for the completion abort and error return block.
package cca_pkg;
   localparam int DATA_W = 64; // Stream data width in bits.
   localparam int SB_W = 8; // Side-band user bus width.
   localparam int SB_DISC = 0; // Abort flag position in the side-band bus.
   localparam int STAT_LSB = 43; // Completion status field low bit in the descriptor.
   localparam logic [2:0] STAT_UR = 3'h1; // Unsupported Request status code.
   localparam logic [2:0] STAT_CA = 3'h4; // Completer Abort status code.
   localparam logic [2:0] ERR_LAST_BEAT = 3'h3; // Index of the final beat of an error completion.
   localparam logic [2:0] IDX_MAX = 3'h7; // Beat index saturates here.
   localparam logic [11:0] REG_CTRL = 12'h000; // Control register byte address.
   localparam logic [11:0] REG_STAT = 12'h004; // Sticky event status, cleared by read.
   localparam logic [11:0] REG_MASK = 12'h008; // Interrupt mask, same layout as status.
   localparam logic [11:0] REG_NCNT = 12'h00c; // Count of nullified packets.
   localparam logic [11:0] REG_STATE = 12'h010; // Live packet state.
   localparam int CTRL_W = 3; // Control register width.
   localparam int CTRL_EP = 0; // Device acts as an endpoint.
   localparam int CTRL_ALIGN = 1; // Address-aligned mode select.
   localparam int CTRL_STALL = 2; // Software hold-off of stream ready.
   localparam logic [2:0] CTRL_RST = 3'h1; // Control value after reset.
   localparam int NEV = 4; // Number of event bits.
   localparam int EV_ABORT = 0; // Abort flag seen.
   localparam int EV_DROP = 1; // Valid dropped inside a packet.
   localparam int EV_LEN = 2; // Error completion of wrong length.
   localparam int EV_LOG = 3; // Error completion header logged.
   localparam logic [3:0] MASK_RST = 4'h0; // Mask value after reset.
   localparam int NCNT_W = 16; // Width of the nullified packet counter.
   // One beat towards the link.
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic last;
      logic nullify;
   } cca_tlp_s;
   // Header log captured from an error completion.
   typedef struct packed {
      logic [31:0] ctl;
      logic [3:0][31:0] req;
   } cca_hdr_s;
endpackage : cca_pkg

// *** rtl/cca_event_irq.sv ***
`timescale 1ns/1ps
`default_nettype none
// Sticky event bits with read-clear and a masked level interrupt.
module cca_event_irq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [cca_pkg::NEV-1:0] ev_set,
   input wire logic [cca_pkg::NEV-1:0] ev_clr,
   input wire logic [cca_pkg::NEV-1:0] ev_mask,
   output logic [cca_pkg::NEV-1:0] status,
   output logic irq
);
   logic [cca_pkg::NEV-1:0] next_status; // Next sticky status.
   logic next_irq; // Next interrupt level.

   // Each bit keeps its event; a set in the clearing cycle wins.
   genvar i;
   generate
      for (i = 0; i < cca_pkg::NEV; i++)
      begin : g_bit
         assign next_status[i] = ev_set[i] | (status[i] & ~ev_clr[i]);
      end
   endgenerate

   // The interrupt is high while any unmasked bit is set.
   always_comb
   begin
      next_irq = |(next_status & ev_mask);
   end

   // Registers the status and the interrupt.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status <= '0;
         irq <= 1'b0;
      end
      else
      begin
         status <= next_status;
         irq <= next_irq;
      end
   end
endmodule : cca_event_irq
`default_nettype wire

// *** rtl/cca_cpl_abort.sv ***
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cca_cpl_abort (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [cca_pkg::DATA_W-1:0] cpl_in_data,
   input wire logic [cca_pkg::SB_W-1:0] cpl_in_sideband,
   input wire logic cpl_in_valid,
   input wire logic cpl_in_last,
   output logic cpl_in_ready,
   output cca_pkg::cca_tlp_s tlp_out,
   output logic tlp_out_valid,
   input wire logic tlp_out_ready,
   output logic aer_internal_err,
   output cca_pkg::cca_hdr_s aer_hdr,
   output logic aer_hdr_valid,
   output logic irq
);
   // Packet tracking states.
   typedef enum logic {CCA_IDLE, CCA_BODY} cca_rx_e;

   cca_rx_e state; // Inside a packet or not.
   cca_rx_e next_state;
   logic pkt_err; // Packet is already errored.
   logic next_err;
   logic pkt_abort; // Packet carried an abort flag.
   logic next_abort;
   logic pkt_errcpl; // Packet is a UR or CA completion.
   logic next_errcpl;
   logic [2:0] beat_idx; // Accepted beats so far in this packet.
   logic [2:0] next_idx;
   cca_pkg::cca_tlp_s next_out;
   logic next_out_valid;
   logic next_ready;
   cca_pkg::cca_hdr_s next_hdr;
   logic next_hdr_valid;
   logic next_aer;
   logic [cca_pkg::NEV-1:0] ev_set; // Events found this cycle.
   logic [cca_pkg::NCNT_W-1:0] ncnt; // Nullified packet count.
   logic [cca_pkg::NCNT_W-1:0] next_ncnt;
   logic [cca_pkg::CTRL_W-1:0] ctrl; // Software control bits.
   logic [cca_pkg::CTRL_W-1:0] next_ctrl;
   logic [cca_pkg::NEV-1:0] mask; // Interrupt mask.
   logic [cca_pkg::NEV-1:0] next_mask;
   logic [cca_pkg::NEV-1:0] status; // Sticky event status.
   logic [cca_pkg::NEV-1:0] ev_clr; // Bits cleared by a status read.
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic take; // A beat is accepted this cycle.
   logic disc; // Abort flag sampled this cycle.
   logic first; // Accepted beat opens a packet.
   logic errcpl; // Accepted beat belongs to an error completion.
   logic [2:0] idx; // Index of the accepted beat.
   logic err_acc; // Error state including this beat.
   logic len_bad; // Error completion length broken on this beat.

   // The flag only counts on a handshake beat.
   assign take = cpl_in_valid & cpl_in_ready;
   assign disc = take & cpl_in_sideband[cca_pkg::SB_DISC];

   // Computes the stream, packet and header log next values.
   always_comb
   begin
      next_state = state;
      next_err = pkt_err;
      next_abort = pkt_abort;
      next_errcpl = pkt_errcpl;
      next_idx = beat_idx;
      next_out = tlp_out;
      next_out_valid = tlp_out_valid;
      next_hdr = aer_hdr;
      next_hdr_valid = 1'b0;
      next_aer = 1'b0;
      next_ncnt = ncnt;
      ev_set = '0;
      first = (state == CCA_IDLE);
      errcpl = 1'b0;
      idx = 3'h0;
      err_acc = 1'b0;
      len_bad = 1'b0;
      // The link side has taken the held beat.
      if (tlp_out_valid && tlp_out_ready)
         next_out_valid = 1'b0;
      // A gap in valid inside a packet poisons the packet.
      if (state == CCA_BODY && !cpl_in_valid)
      begin
         next_err = 1'b1;
         ev_set[cca_pkg::EV_DROP] = 1'b1;
      end
      // An accepted beat.
      if (take)
      begin
         // The status field sits in the first beat of the descriptor.
         errcpl = first ?
            (cpl_in_data[cca_pkg::STAT_LSB +: 3] == cca_pkg::STAT_UR ||
             cpl_in_data[cca_pkg::STAT_LSB +: 3] == cca_pkg::STAT_CA) : pkt_errcpl;
         idx = first ? 3'h0 : beat_idx;
         // The abort is held for the rest of the packet.
         err_acc = pkt_err | disc;
         if (disc)
         begin
            ev_set[cca_pkg::EV_ABORT] = 1'b1;
            // Only the first flag of a packet is reported upstream.
            next_aer = ctrl[cca_pkg::CTRL_EP] & ~pkt_abort;
         end
         // An error completion must end on its fourth beat.
         len_bad = errcpl & (cpl_in_last != (idx == cca_pkg::ERR_LAST_BEAT));
         if (len_bad)
         begin
            ev_set[cca_pkg::EV_LEN] = 1'b1;
            err_acc = 1'b1;
         end
         // Dwords are packed identically in both alignment modes.
         if (errcpl)
         begin
            unique case (idx)
               3'h1: next_hdr.ctl = cpl_in_data[63:32];
               3'h2:
               begin
                  next_hdr.req[0] = cpl_in_data[31:0];
                  next_hdr.req[1] = cpl_in_data[63:32];
               end
               3'h3:
               begin
                  next_hdr.req[2] = cpl_in_data[31:0];
                  next_hdr.req[3] = cpl_in_data[63:32];
               end
               default: next_hdr = aer_hdr;
            endcase
         end
         // A clean error completion hands its header to the log.
         if (errcpl && cpl_in_last && !err_acc)
         begin
            next_hdr_valid = 1'b1;
            ev_set[cca_pkg::EV_LOG] = 1'b1;
         end
         // The beat moves on with its poison mark.
         next_out.data = cpl_in_data;
         next_out.last = cpl_in_last;
         next_out.nullify = err_acc;
         next_out_valid = 1'b1;
         if (cpl_in_last && err_acc)
            next_ncnt = ncnt + 16'h0001;
         // The last beat closes the packet and drops its error state.
         if (cpl_in_last)
         begin
            next_state = CCA_IDLE;
            next_err = 1'b0;
            next_abort = 1'b0;
            next_errcpl = 1'b0;
            next_idx = 3'h0;
         end
         else
         begin
            next_state = CCA_BODY;
            next_err = err_acc;
            next_abort = pkt_abort | disc;
            next_errcpl = errcpl;
            next_idx = (idx == cca_pkg::IDX_MAX) ? idx : idx + 3'h1;
         end
      end
      // Ready falls while the beat store is full or software stalls.
      next_ready = ~next_out_valid & ~ctrl[cca_pkg::CTRL_STALL];
   end

   // Registers the stream and packet state.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= CCA_IDLE;
         pkt_err <= 1'b0;
         pkt_abort <= 1'b0;
         pkt_errcpl <= 1'b0;
         beat_idx <= 3'h0;
         tlp_out <= '0;
         tlp_out_valid <= 1'b0;
         cpl_in_ready <= 1'b0;
         aer_hdr <= '0;
         aer_hdr_valid <= 1'b0;
         aer_internal_err <= 1'b0;
         ncnt <= '0;
      end
      else
      begin
         state <= next_state;
         pkt_err <= next_err;
         pkt_abort <= next_abort;
         pkt_errcpl <= next_errcpl;
         beat_idx <= next_idx;
         tlp_out <= next_out;
         tlp_out_valid <= next_out_valid;
         cpl_in_ready <= next_ready;
         aer_hdr <= next_hdr;
         aer_hdr_valid <= next_hdr_valid;
         aer_internal_err <= next_aer;
         ncnt <= next_ncnt;
      end
   end

   // Computes the APB answer and register writes; pready rises in the first access cycle, so no wait state.
   always_comb
   begin
      next_pready = psel & ~penable;
      next_prdata = 32'h0;
      next_pslverr = 1'b0;
      next_ctrl = ctrl;
      next_mask = mask;
      ev_clr = '0;
      // Read data and the error answer are formed in the setup cycle.
      if (psel && !penable)
      begin
         unique case (paddr)
            cca_pkg::REG_CTRL: next_prdata = {29'h0, ctrl};
            cca_pkg::REG_STAT: next_prdata = {28'h0, status};
            cca_pkg::REG_MASK: next_prdata = {28'h0, mask};
            cca_pkg::REG_NCNT: next_prdata = {16'h0, ncnt};
            cca_pkg::REG_STATE:
               next_prdata = {26'h0, state == CCA_BODY, pkt_err, pkt_abort, beat_idx};
            default: next_pslverr = 1'b1;
         endcase
      end
      // The access edge commits a write or clears what was read.
      if (psel && penable && pready)
      begin
         if (pwrite && paddr == cca_pkg::REG_CTRL)
            next_ctrl = pwdata[cca_pkg::CTRL_W-1:0];
         if (pwrite && paddr == cca_pkg::REG_MASK)
            next_mask = pwdata[cca_pkg::NEV-1:0];
         if (!pwrite && paddr == cca_pkg::REG_STAT)
            ev_clr = prdata[cca_pkg::NEV-1:0];
      end
   end

   // Registers the bus answer and the software bits.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
         ctrl <= cca_pkg::CTRL_RST;
         mask <= cca_pkg::MASK_RST;
      end
      else
      begin
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         ctrl <= next_ctrl;
         mask <= next_mask;
      end
   end

   // Sticky event status and interrupt.
   cca_event_irq cca_event_irq_i (
      .pclk(pclk),
      .presetn(presetn),
      .ev_set(ev_set),
      .ev_clr(ev_clr),
      .ev_mask(mask),
      .status(status),
      .irq(irq)
   );

   // Checks run on the bus clock and stop during reset.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // A packet is marked aborted only after a sampled flag.
   abort_sample_a: assert property ($rose(pkt_abort) |-> $past(take) &&
      $past(cpl_in_sideband[cca_pkg::SB_DISC]))
      else $error("abort state set without a sampled flag");

   // An aborted packet leaves with its poison mark on the last beat.
   abort_null_a: assert property ((take && cpl_in_last && (pkt_abort || disc)) |=>
      tlp_out_valid && tlp_out.last && tlp_out.nullify)
      else $error("aborted packet not nullified");

   // The abort state holds until the packet closes.
   abort_sticky_a: assert property ((pkt_abort && !(take && cpl_in_last)) |=>
      pkt_abort && pkt_err)
      else $error("abort state lost inside packet");

   // An endpoint raises one internal error pulse for a fresh abort.
   aer_report_a: assert property ((disc && !pkt_abort && ctrl[cca_pkg::CTRL_EP]) |=>
      aer_internal_err ##1 !aer_internal_err)
      else $error("internal error not reported");

   // A clean four-beat error completion is logged the next cycle.
   err_len_a: assert property ((take && pkt_errcpl && beat_idx == 3'h3 &&
      cpl_in_last && !pkt_err && !disc) |=> aer_hdr_valid && !tlp_out.nullify)
      else $error("error completion not logged");

   // A software stall or a full store keeps ready low.
   stall_ready_a: assert property ((ctrl[cca_pkg::CTRL_STALL] ||
      (tlp_out_valid && !tlp_out_ready)) |=> !cpl_in_ready)
      else $error("ready high while unable to accept");

   // A gap in valid inside a packet poisons it.
   drop_null_a: assert property ((state == CCA_BODY && !cpl_in_valid) |=>
      pkt_err && status[cca_pkg::EV_DROP])
      else $error("valid gap not treated as error");
endmodule : cca_cpl_abort
`default_nettype wire

// *** verification/cca_client_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Client side of the completion stream: offers beats and keeps the handshake duties.
module cca_client_model (
   input wire logic pclk,
   input wire logic cpl_in_ready,
   output logic [cca_pkg::DATA_W-1:0] cpl_in_data,
   output logic [cca_pkg::SB_W-1:0] cpl_in_sideband,
   output logic cpl_in_valid,
   output logic cpl_in_last,
   output logic tmo
);
   // Outputs start idle so no beat is offered during reset.
   initial
   begin
      cpl_in_data = 64'h0;
      cpl_in_sideband = 8'h00;
      cpl_in_valid = 1'b0;
      cpl_in_last = 1'b0;
      tmo = 1'b0;
   end
   // Offers one beat and holds it, abort flag too, until ready is seen at an edge.
   task automatic beat(input logic [63:0] d, input logic ab, input logic lst);
      int n;
      cpl_in_data <= d;
      cpl_in_sideband <= {7'h00, ab};
      cpl_in_valid <= 1'b1;
      cpl_in_last <= lst;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (cpl_in_ready !== 1'b1 && n < 400);
      // A wait that runs out is flagged to the bench.
      if (n >= 400)
         tmo <= 1'b1;
   endtask : beat
   // Releases the stream; data and spare bits flip so stale values never look valid.
   task automatic idle();
      cpl_in_valid <= 1'b0;
      cpl_in_last <= 1'b0;
      cpl_in_data <= ~cpl_in_data;
      cpl_in_sideband <= {~cpl_in_sideband[7:1], 1'b0};
   endtask : idle
   // Sends a packet; abort covers beats ab_at to ab_end, a gap follows beat gap_at.
   task automatic send_pkt(input logic [63:0] dq[$], input int ab_at, input int ab_end,
      input int gap_at);
      for (int i = 0; i < dq.size(); i++)
      begin
         beat(dq[i], i >= ab_at && i <= ab_end, i == dq.size() - 1);
         // A gap breaks the packet on purpose when the bench asks for it.
         if (i == gap_at)
         begin
            idle();
            @(posedge pclk);
         end
      end
      idle();
      @(posedge pclk);
   endtask : send_pkt
endmodule : cca_client_model
`default_nettype wire

// *** verification/cca_cpl_abort_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: APB register traffic plus packets from the client model.
module cca_cpl_abort_tb;
   logic pclk = 1'b0; // 40 MHz clock.
   logic presetn = 1'b0; // Reset, low at the start.
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request.
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, irq, tmo, aer_internal_err, aer_hdr_valid;
   logic [63:0] cpl_in_data;
   logic [7:0] cpl_in_sideband;
   logic cpl_in_valid, cpl_in_last, cpl_in_ready, tlp_out_valid;
   logic tlp_out_ready = 1'b0; // Link side acceptance.
   logic slow = 1'b0; // When set the link accepts every other cycle.
   cca_pkg::cca_tlp_s tlp_out;
   cca_pkg::cca_hdr_s aer_hdr;
   cca_pkg::cca_tlp_s outq[$]; // Beats seen on the link side.
   logic [63:0] dq[$]; // Packet being sent.
   int miscompares = 0, cmp_count = 0, n_aer = 0, n_hdr = 0;
   cca_cpl_abort cca_cpl_abort_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpl_in_data(cpl_in_data),
      .cpl_in_sideband(cpl_in_sideband), .cpl_in_valid(cpl_in_valid),
      .cpl_in_last(cpl_in_last), .cpl_in_ready(cpl_in_ready), .tlp_out(tlp_out),
      .tlp_out_valid(tlp_out_valid), .tlp_out_ready(tlp_out_ready),
      .aer_internal_err(aer_internal_err), .aer_hdr(aer_hdr),
      .aer_hdr_valid(aer_hdr_valid), .irq(irq));
   cca_client_model cca_client_model_i (.pclk(pclk), .cpl_in_ready(cpl_in_ready),
      .cpl_in_data(cpl_in_data), .cpl_in_sideband(cpl_in_sideband),
      .cpl_in_valid(cpl_in_valid), .cpl_in_last(cpl_in_last), .tmo(tmo));
   // Clock toggles every half period.
   always #12.5 pclk = ~pclk;
   // Link accepts every cycle, or every other one when slow.
   always @(posedge pclk)
      tlp_out_ready <= slow ? ~tlp_out_ready : 1'b1;
   // Collects link beats, counts report pulses and stops on a client timeout.
   always @(posedge pclk)
   begin
      if (tlp_out_valid === 1'b1 && tlp_out_ready === 1'b1)
         outq.push_back(tlp_out);
      if (aer_internal_err === 1'b1)
         n_aer++;
      if (aer_hdr_valid === 1'b1)
         n_hdr++;
      if (tmo === 1'b1)
      begin
         miscompares++;
         end_of_test();
      end
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic end_of_test();
      $display("Compared %0d, mismatched %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // Compares a seen value with the expected one.
   task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      // A slave that never answers ends the run.
      if (n >= 50)
      begin
         miscompares++;
         end_of_test();
      end
   endtask : apb
   // Reads a register and compares data and error response.
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h0);
      check("rdata", 160'(rd), 160'(exp));
      check("slverr", 160'(err), 160'(exp_err));
   endtask : rd_chk
   // Builds n plain beats; beat zero keeps a success status.
   task automatic mk(input int n, input logic [63:0] seed);
      dq.delete();
      for (int i = 0; i < n; i++)
         dq.push_back(seed + 64'(i) * 64'h0101_0101_0101_0101);
   endtask : mk
   // Builds an error completion, dropping the final beat when short is set.
   task automatic mk_err(input logic [2:0] st, input logic short);
      dq.delete();
      dq.push_back(64'h20 | (64'(st) << cca_pkg::STAT_LSB));
      dq.push_back({32'h0003_5a21, 32'h0000_0004});
      dq.push_back(64'h2222_2222_1111_1111);
      dq.push_back(64'h4444_4444_3333_3333);
      if (short)
         void'(dq.pop_back());
   endtask : mk_err
   // Waits for the packet on the link and compares data, last and nullify.
   task automatic expect_out(input logic [7:0] nexp, input logic [7:0] ncare);
      int n;
      n = 0;
      while (outq.size() < dq.size() && n < 200)
      begin
         @(posedge pclk);
         n++;
      end
      check("beats", 160'(outq.size()), 160'(dq.size()));
      for (int i = 0; i < dq.size() && i < outq.size(); i++)
      begin
         check("data", 160'(outq[i].data), 160'(dq[i]));
         check("last", 160'(outq[i].last), 160'(i == dq.size() - 1));
         if (ncare[i])
            check("nullify", 160'(outq[i].nullify), 160'(nexp[i]));
      end
      // A packet that never completes counts as a mismatch and ends the run.
      if (outq.size() < dq.size())
      begin
         miscompares++;
         end_of_test();
      end
      outq.delete();
   endtask : expect_out
   // Main sequence of scenarios.
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd_chk(cca_pkg::REG_CTRL, 32'(cca_pkg::CTRL_RST), 1'b0);
      rd_chk(cca_pkg::REG_MASK, 32'(cca_pkg::MASK_RST), 1'b0);
      rd_chk(12'h014, 32'h0, 1'b1);
      apb(1'b1, cca_pkg::REG_MASK, 32'hf);
      slow <= 1'b1;
      // Plain packet against a stalling link.
      mk(3, 64'h10);
      cca_client_model_i.send_pkt(dq, 9, 9, 9);
      expect_out(8'h00, 8'h07);
      // Abort in beat one only, so the later beats stay errored.
      mk(4, 64'h20);
      cca_client_model_i.send_pkt(dq, 1, 1, 9);
      expect_out(8'h0e, 8'h0f);
      check("aer", 160'(n_aer), 160'(1));
      check("irq", 160'(irq), 160'(1));
      rd_chk(cca_pkg::REG_STAT, 32'h1, 1'b0);
      rd_chk(cca_pkg::REG_STAT, 32'h0, 1'b0);
      check("irq", 160'(irq), 160'(0));
      // Software holds ready off while the client holds an aborting beat.
      apb(1'b1, cca_pkg::REG_CTRL, 32'h5);
      mk(1, 64'h30);
      fork
         cca_client_model_i.send_pkt(dq, 0, 0, 9);
         begin
            repeat (4) @(posedge pclk);
            check("held", 160'(cpl_in_ready), 160'(0));
            check("held", 160'(outq.size()), 160'(0));
            rd_chk(cca_pkg::REG_STATE, 32'h0, 1'b0);
            apb(1'b1, cca_pkg::REG_CTRL, 32'h1);
         end
      join
      expect_out(8'h01, 8'h01);
      check("aer", 160'(n_aer), 160'(2));
      // Not an endpoint: nullified but not reported.
      apb(1'b1, cca_pkg::REG_CTRL, 32'h0);
      mk(2, 64'h40);
      cca_client_model_i.send_pkt(dq, 0, 0, 9);
      expect_out(8'h03, 8'h03);
      check("aer", 160'(n_aer), 160'(2));
      rd_chk(cca_pkg::REG_STAT, 32'h1, 1'b0);
      // Both error codes: UR in the default mode, CA in the address-aligned mode.
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, cca_pkg::REG_CTRL, k ? 32'h3 : 32'h1);
         rd_chk(cca_pkg::REG_CTRL, k ? 32'h3 : 32'h1, 1'b0);
         mk_err(k ? cca_pkg::STAT_CA : cca_pkg::STAT_UR, 1'b0);
         cca_client_model_i.send_pkt(dq, 9, 9, 9);
         expect_out(8'h00, 8'h0f);
         check("hdr", aer_hdr, {dq[1][63:32], dq[3], dq[2]});
         check("hdr cnt", 160'(n_hdr), 160'(k + 1));
      end
      rd_chk(cca_pkg::REG_STAT, 32'h8, 1'b0);
      // Error completion one beat short.
      mk_err(cca_pkg::STAT_UR, 1'b1);
      cca_client_model_i.send_pkt(dq, 9, 9, 9);
      expect_out(8'h04, 8'h07);
      check("hdr cnt", 160'(n_hdr), 160'(2));
      rd_chk(cca_pkg::REG_STAT, 32'h4, 1'b0);
      // Valid gap after the first beat.
      mk(3, 64'h50);
      cca_client_model_i.send_pkt(dq, 9, 9, 0);
      expect_out(8'h06, 8'h07);
      rd_chk(cca_pkg::REG_STAT, 32'h2, 1'b0);
      rd_chk(cca_pkg::REG_NCNT, 32'h5, 1'b0);
      end_of_test();
   end
endmodule : cca_cpl_abort_tb
`default_nettype wire
